// File: verilog/link_receive_phase_fifo.sv
// Receive phase FIFO: link beats in on the forwarded clock, lines out
// on the core clock.
// Assumes the core clock shares the link's time base and reads one line
// per cycle once started.
//
// Notes on behaviour
// - Start reads only after sampled-low deassertion seen
// - Hold write-to-read gap for early-then-late edges
// - Hold read-to-overwrite gap for late-then-early edges
// - Depth covers twice the dynamic variation sum
// - Allow one receive bit of sampling error
// - Extra entries hold a whole wide line
// - Read line only after all beats written
// - Add lane clock skew to transmit uncertainty
// - Subtract synchroniser delay from read start
// - Budget 733 ps reference clock uncertainty
// - Budget 3500 ps each PLL, both sides
// - Budget 250 ps variable lane skew
// - Budget half of the 1000 ps constant lane skew
// - Budget rate-dependent transmit transfer uncertainty
// - Budget rate-dependent receive transfer uncertainty
// - Separation may be trimmed from measurement
// - Write on link clock, read on core
// - Read pointer set once, never adjusted
// - Entries at least phase span over bit time
`timescale 1ns/1ps
`include "link_rx_defs.svh"

module link_receive_phase_fifo #(
   parameter int TBIT_PS        = `TBIT_1600_PS,
   parameter int XMIT_XFER_PS   = `XMIT_XFER_1600_PS,
   parameter int RECV_XFER_PS   = `RECV_XFER_1600_PS,
   parameter int SEP_TRIM_BEATS = 0
) (
   // Core clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     rst_n_i,
   // Link side
   input  wire logic                     forwarded_clock_input_i,
   input  link_rx_pkg::link_beat_s       link_beat_i,
   // Core side
   output logic [`LINE_W-1:0]            rd_data_o,
   output logic                          rd_valid_o,
   output link_rx_pkg::line_ptr_t        line_sep_o,
   output logic                          sep_err_o
);

   import link_rx_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Phase budget and sizing

   localparam int RATIO = `LINE_BEATS;
   localparam int EP    = `ENTRY_PTR_W;
   localparam int LP    = `LINE_PTR_W;
   localparam int WC    = `WAIT_CNT_W;

   localparam int XMIT_SIDE_PS =
      `REF_CLK_VAR_PS
      + `XMIT_PLL_PHASE_BUDGET_PS
      + XMIT_XFER_PS;
   localparam int LANE_SKEW_PS =
      `LANE_VAR_PS;
   localparam int RECV_SIDE_PS =
      `RECV_PLL_PHASE_BUDGET_PS
      + RECV_XFER_PS;
   localparam int VARIANT_PS =
      XMIT_SIDE_PS + LANE_SKEW_PS
      + RECV_SIDE_PS;
   localparam int SAMPLE_PS =
      `SAMPLE_ERR_BITS * TBIT_PS;
   localparam int SEP_PS =
      VARIANT_PS + SAMPLE_PS
      + `LANE_CONST_PS / 2;

   // Gap in beats, plus a line's worth so a line is full before read
   localparam int SEP_BEATS =
      ceil_div(SEP_PS, TBIT_PS) + RATIO - 1
      - SEP_TRIM_BEATS;

   // Both error directions plus one bit, plus room for a held line
   localparam int PHASE_PS = 2 * SEP_PS + TBIT_PS;
   localparam int MIN_BEATS =
      ceil_div(PHASE_PS, TBIT_PS)
      + RATIO - 1;
   localparam int DEPTH_BEATS = 1 << EP;

   localparam int SEP_LINES = ceil_div(SEP_BEATS, RATIO);
   localparam int START_RAW = SEP_LINES - `SYNC_STAGES;
   localparam int START_WAIT = (START_RAW < 1) ? 1 : START_RAW;

   localparam logic [WC-1:0] WAIT_LAST = WC'(START_WAIT - 1);
   localparam logic [WC-1:0] CNT_ONE   = WC'(1);
   localparam logic [EP-1:0] BEAT_ONE  = EP'(1);
   localparam line_ptr_t     LINE_ONE  = LP'(1);

   ////////////////////////////////////////////////////////////////////
   // Reset release, core then link domain

   logic [1:0] rst_q;
   logic       rst_n;
   logic [1:0] wr_rst_q;
   logic       wr_rst_n;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   assign rst_n = rst_q[1];

   always_ff @(posedge forwarded_clock_input_i or negedge rst_n) begin
      if (!rst_n) begin
         wr_rst_q <= 2'h0;
      end else begin
         wr_rst_q <= {wr_rst_q[0], 1'b1};
      end
   end

   assign wr_rst_n = wr_rst_q[1];

   ////////////////////////////////////////////////////////////////////
   // Write side, forwarded clock domain

   wr_state_s wr_reg;
   wr_state_s wr_next;

   always_comb begin
      wr_next      = wr_reg;
      wr_next.beat = link_beat_i;
      case (wr_reg.mode)
         WR_IDLE: begin
            if (wr_reg.beat.control_line_input) begin
               wr_next.mode = WR_ARMED;
            end
         end
         WR_ARMED: begin
            if (!wr_reg.beat.control_line_input &&
                wr_reg.beat.cmd_addr_data_input == '0) begin
               wr_next.mode = WR_RUN;
            end
         end
         WR_RUN: begin
            wr_next.ptr = wr_reg.ptr + BEAT_ONE;
         end
         default: begin
            wr_next.mode = WR_IDLE;
         end
      endcase
      // Line being filled, gray coded for the crossing
      wr_next.gray = to_gray(wr_next.ptr[EP-1:EP-LP]);
   end

   always_ff @(posedge forwarded_clock_input_i or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wr_reg <= '0;
      end else begin
         wr_reg <= wr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read side, core clock domain

   rd_state_s rd_reg;
   rd_state_s rd_next;

   always_comb begin
      rd_next        = rd_reg;
      // Mode bit 1 alone marks running, so it crosses glitch free
      rd_next.seen_a = wr_reg.mode[1];
      rd_next.seen_b = rd_reg.seen_a;
      rd_next.gray_a = wr_reg.gray;
      rd_next.gray_b = rd_reg.gray_a;
      case (rd_reg.mode)
         RD_IDLE: begin
            if (rd_reg.seen_b) begin
               rd_next.mode = RD_WAIT;
               rd_next.cnt  = '0;
            end
         end
         RD_WAIT: begin
            rd_next.cnt = rd_reg.cnt + CNT_ONE;
            if (rd_reg.cnt == WAIT_LAST) begin
               rd_next.mode = RD_RUN;
            end
         end
         RD_RUN: begin
            // Free running from here: no slips, no re-centring
            rd_next.ptr = rd_reg.ptr + LINE_ONE;
         end
         default: begin
            rd_next.mode = RD_IDLE;
         end
      endcase
      rd_next.valid = (rd_reg.mode == RD_RUN);
      rd_next.sep   = from_gray(rd_reg.gray_b) - rd_reg.ptr;
      // Reading the line still being filled means the gap collapsed
      rd_next.err   = rd_reg.err |
                      ((rd_reg.mode == RD_RUN) &&
                       (rd_next.sep == '0));
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_reg <= '0;
      end else begin
         rd_reg <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Beat memory

   phase_fifo_mem #(
      .LANE_W (`LANE_W),
      .RATIO  (RATIO),
      .DEPTH  (DEPTH_BEATS)
   ) u_mem (
      .wr_clk_i   (forwarded_clock_input_i),
      .wr_en_i    (wr_reg.mode == WR_RUN),
      .wr_addr_i  (wr_reg.ptr),
      .wr_data_i  (wr_reg.beat.cmd_addr_data_input),
      .rd_clk_i   (mclk_i),
      .rd_rst_n_i (rst_n),
      .rd_en_i    (rd_reg.mode == RD_RUN),
      .rd_line_i  (rd_reg.ptr),
      .rd_data_o  (rd_data_o)
   );

   assign rd_valid_o = rd_reg.valid;
   assign line_sep_o = rd_reg.sep;
   assign sep_err_o  = rd_reg.err;

   ////////////////////////////////////////////////////////////////////
   // Checks

   logic [WC-1:0] age_q;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= '0;
      end else if (rd_reg.mode == RD_WAIT) begin
         age_q <= age_q + CNT_ONE;
      end else if (rd_reg.mode == RD_IDLE) begin
         age_q <= '0;
      end
   end

   a_wr_ptr_step: assert property (
      @(posedge forwarded_clock_input_i) disable iff (!wr_rst_n)
      (wr_reg.mode == WR_RUN) |=>
         (wr_reg.mode == WR_RUN) &&
         (wr_reg.ptr == EP'($past(wr_reg.ptr) + 1)))
      else $error("write pointer did not step once per beat");

   a_wr_start_cond: assert property (
      @(posedge forwarded_clock_input_i) disable iff (!wr_rst_n)
      $rose(wr_reg.mode == WR_RUN) |->
         $past(!wr_reg.beat.control_line_input &&
               (wr_reg.beat.cmd_addr_data_input == '0)) &&
         (wr_reg.ptr == '0))
      else $error("write side started without a low beat");

   a_rd_after_seen: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      $rose(rd_reg.mode == RD_WAIT) |->
         $past(rd_reg.seen_b) && $past(rd_reg.mode == RD_IDLE))
      else $error("read wait began before deassertion was seen");

   a_rd_start_wait: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      $rose(rd_reg.mode == RD_RUN) |->
         (age_q == WC'(START_WAIT)) && (rd_reg.ptr == '0))
      else $error("read pointer start offset is wrong");

   a_rd_no_adjust: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_reg.mode == RD_RUN) |=>
         (rd_reg.mode == RD_RUN) &&
         (rd_reg.ptr == LP'($past(rd_reg.ptr) + 1)))
      else $error("read pointer was adjusted after start");

   a_valid_track: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      $rose(rd_reg.mode == RD_RUN) |->
         !rd_valid_o ##1 rd_valid_o [*3])
      else $error("line valid did not follow read start");

   a_depth_fit: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_reg.mode == RD_WAIT) |->
         (DEPTH_BEATS >= MIN_BEATS) &&
         (MIN_BEATS > 2 * ceil_div(SEP_PS, TBIT_PS)))
      else $error("FIFO depth below the phase span");

   a_sep_room: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_reg.mode == RD_WAIT) |->
         (DEPTH_BEATS - SEP_LINES * RATIO >=
          ceil_div(SEP_PS, TBIT_PS) + RATIO - 1))
      else $error("no read-to-overwrite room left");

   a_err_sticky: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      sep_err_o |=> sep_err_o ##1 sep_err_o)
      else $error("separation error flag dropped");

   a_err_set: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_reg.mode == RD_RUN) &&
      (from_gray(rd_reg.gray_b) == rd_reg.ptr) |=> sep_err_o)
      else $error("collapsed gap did not raise the error flag");

   a_valid_quiet: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_reg.mode != RD_RUN) |=> !rd_valid_o)
      else $error("line valid rose before reading started");

   a_valid_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_n)
      rd_valid_o |=> rd_valid_o)
      else $error("line valid dropped while reading");

   a_wr_ptr_hold: assert property (
      @(posedge forwarded_clock_input_i) disable iff (!wr_rst_n)
      (wr_reg.mode != WR_RUN) |=> (wr_reg.ptr == $past(wr_reg.ptr)))
      else $error("write pointer moved before start");

   a_gray_step: assert property (
      @(posedge forwarded_clock_input_i) disable iff (!wr_rst_n)
      1'b1 |=>
         ($countones(wr_reg.gray ^ $past(wr_reg.gray)) <= 1))
      else $error("crossing pointer changed more than one bit");

endmodule // link_receive_phase_fifo

// File: verilog/link_rx_defs.svh
// Constants for the receive phase FIFO: widths, phase budgets, timing.
// Assumes nothing; definitions only.
`ifndef LINK_RX_DEFS_SVH
`define LINK_RX_DEFS_SVH

// Data path shape
`define LANE_W             8
`define LINE_BEATS         8
`define LINE_W             64
`define ENTRY_PTR_W        6
`define LINE_PTR_W         3
`define WAIT_CNT_W         8

// Crossing and local clock
`define SYNC_STAGES        2
`define MCLK_PERIOD_PS     50000

// Phase budgets in ps, worst case
`define REF_CLK_VAR_PS             733
`define XMIT_PLL_PHASE_BUDGET_PS   3500
`define RECV_PLL_PHASE_BUDGET_PS   3500
`define LANE_VAR_PS                250
`define LANE_CONST_PS              1000
`define XMIT_XFER_400_PS           918
`define XMIT_XFER_1600_PS          228
`define XMIT_XFER_MIN_PS           51
`define RECV_XFER_400_PS           425
`define RECV_XFER_1600_PS          81
`define RECV_XFER_2800_PS          46

// Link rate and bit time
`define LINK_RATE_1600_MTS         1600
`define TBIT_1600_PS               (1000000 / `LINK_RATE_1600_MTS)
`define SAMPLE_ERR_BITS            1

`endif

// File: verilog/link_rx_pkg.sv
// Types and helpers for the receive phase FIFO.
// Assumes link_rx_defs.svh is on the include path.
`include "link_rx_defs.svh"

package link_rx_pkg;

   typedef enum logic [1:0] {
      WR_IDLE  = 2'b00,
      WR_ARMED = 2'b01,
      WR_RUN   = 2'b11
   } wr_mode_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_RUN  = 2'b11
   } rd_mode_e;

   typedef logic [`LINE_PTR_W-1:0] line_ptr_t;

   typedef struct packed {
      logic                control_line_input;
      logic [`LANE_W-1:0]  cmd_addr_data_input;
   } link_beat_s;

   typedef struct packed {
      link_beat_s              beat;
      wr_mode_e                mode;
      logic [`ENTRY_PTR_W-1:0] ptr;
      line_ptr_t               gray;
   } wr_state_s;

   typedef struct packed {
      logic                   seen_a;
      logic                   seen_b;
      line_ptr_t              gray_a;
      line_ptr_t              gray_b;
      rd_mode_e               mode;
      logic [`WAIT_CNT_W-1:0] cnt;
      line_ptr_t              ptr;
      logic                   valid;
      line_ptr_t              sep;
      logic                   err;
   } rd_state_s;

   function automatic int ceil_div(input int a, input int b);
      return (a + b - 1) / b;
   endfunction

   function automatic line_ptr_t to_gray(input line_ptr_t b);
      return b ^ (b >> 1);
   endfunction

   function automatic line_ptr_t from_gray(input line_ptr_t g);
      line_ptr_t b;
      b[`LINE_PTR_W-1] = g[`LINE_PTR_W-1];
      for (int i = `LINE_PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// File: verilog/phase_fifo_mem.sv
// Dual-clock beat memory: narrow writes, whole-line registered reads.
// Assumes write and read addresses are kept apart by the caller.
`timescale 1ns/1ps
`include "link_rx_defs.svh"

module phase_fifo_mem #(
   parameter int LANE_W = `LANE_W,
   parameter int RATIO  = `LINE_BEATS,
   parameter int DEPTH  = 1 << `ENTRY_PTR_W
) (
   // Write port, link clock
   input  wire logic                         wr_clk_i,
   input  wire logic                         wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0]     wr_addr_i,
   input  wire logic [LANE_W-1:0]            wr_data_i,
   // Read port, core clock
   input  wire logic                         rd_clk_i,
   input  wire logic                         rd_rst_n_i,
   input  wire logic                         rd_en_i,
   input  wire logic [$clog2(DEPTH/RATIO)-1:0] rd_line_i,
   output logic      [RATIO*LANE_W-1:0]      rd_data_o
);

   localparam int AW = $clog2(DEPTH);
   localparam int SW = $clog2(RATIO);

   logic [LANE_W-1:0] mem [DEPTH];

   always_ff @(posedge wr_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // First beat of a line lands in the low lane
   always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
      if (!rd_rst_n_i) begin
         rd_data_o <= '0;
      end else if (rd_en_i) begin
         for (int i = 0; i < RATIO; i++) begin
            rd_data_o[i*LANE_W +: LANE_W] <=
               mem[{rd_line_i, SW'(i)}];
         end
      end
   end

endmodule // phase_fifo_mem

// File: verif/link_tx_model.sv
// Far-side transmitter model: forwards a free-running link clock and
// one beat per rising edge of it.
// Assumes the receiver samples each beat on the rising forwarded edge.
`timescale 1ns/1ps
`include "link_rx_defs.svh"

module link_tx_model #(
   parameter int HALF_NS  = 80,
   parameter int PHASE_NS = 37
) (
   // Forwarded link outputs
   output logic                     fwd_clk_o,
   output link_rx_pkg::link_beat_s  beat_o
);
   import link_rx_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Free-running forwarded clock, phase unrelated to the core clock
   initial begin
      fwd_clk_o = 1'b0;
      beat_o    = '0;
      #(PHASE_NS);
      forever #(HALF_NS) fwd_clk_o = ~fwd_clk_o;
   end

   ////////////////////////////////////////////////////////////////////////
   // One beat: change after a falling edge, hold over the rising edge
   task automatic send(input logic ctl, input logic [`LANE_W-1:0] data);
      @(negedge fwd_clk_o);
      beat_o.control_line_input  = ctl;
      beat_o.cmd_addr_data_input = data;
      @(posedge fwd_clk_o);
   endtask

endmodule // link_tx_model

// File: verif/tb.sv
// Testbench for the receive phase FIFO: init sequence, line assembly,
// separation error and reset in mid-run.
// Assumes the link model runs a free 160 ns forwarded clock.
`timescale 1ns/1ps
`include "link_rx_defs.svh"

module tb;
   import link_rx_pkg::*;

   logic                mclk       = 1'b0;
   logic                rst_n      = 1'b0;
   logic                fwd_clk;
   link_beat_s          beat;
   logic [`LINE_W-1:0]  rd_data;
   logic                rd_valid;
   line_ptr_t           line_sep;
   logic                sep_err;
   int                  mismatches = 0;
   int                  n_checks   = 0;
   int                  rd_n       = 0;

   always #25 mclk = ~mclk;

   // Lines read since valid went high
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rd_n <= 0;
      else if (rd_valid === 1'b1) rd_n <= rd_n + 1;
   end

   link_tx_model link_tx_model_inst (
      .fwd_clk_o (fwd_clk),
      .beat_o    (beat)
   );

   link_receive_phase_fifo link_receive_phase_fifo_inst (
      .mclk_i                  (mclk),
      .rst_n_i                 (rst_n),
      .forwarded_clock_input_i (fwd_clk),
      .link_beat_i             (beat),
      .rd_data_o               (rd_data),
      .rd_valid_o              (rd_valid),
      .line_sep_o              (line_sep),
      .sep_err_o               (sep_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Expected data
   function automatic logic [`LANE_W-1:0] pat(input int e);
      int t;
      t = (e % (1 << `ENTRY_PTR_W)) * 37 + 19;
      return t[`LANE_W-1:0];
   endfunction

   function automatic logic [`LINE_W-1:0] exp_line(input int l);
      logic [`LINE_W-1:0] v;
      for (int j = 0; j < `LINE_BEATS; j++) begin
         v[j*`LANE_W +: `LANE_W] = pat(l * `LINE_BEATS + j);
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Compare and closing
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_line(input logic [`LINE_W-1:0] got,
                           input logic [`LINE_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wait_valid;
      int i;
      i = 0;
      while (rd_valid !== 1'b1 && i < 40) begin
         @(negedge mclk);
         i++;
      end
      chk_bit(rd_valid, 1'b1);
      if (rd_valid !== 1'b1) stop_test();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      chk_bit(rd_valid, 1'b0);
      chk_bit(sep_err, 1'b0);
      chk_line(rd_data, '0);
      chk_line(`LINE_W'(line_sep), '0);
      rst_n = 1'b1;
      $display("t_reset done");
   endtask

   task automatic t_idle;
      repeat (6) link_tx_model_inst.send(1'b0, 8'h00);
      repeat (8) @(negedge mclk);
      chk_bit(rd_valid, 1'b0);
      repeat (3) link_tx_model_inst.send(1'b1, 8'h00);
      repeat (3) link_tx_model_inst.send(1'b0, 8'h5a);
      repeat (8) @(negedge mclk);
      chk_bit(rd_valid, 1'b0);
      chk_bit(sep_err, 1'b0);
      chk_line(`LINE_W'(line_sep), '0);
      $display("t_idle done");
   endtask

   task automatic t_start;
      repeat (2) link_tx_model_inst.send(1'b1, 8'h00);
      link_tx_model_inst.send(1'b0, 8'h00);
      fork
         for (int e = 0; e < 96; e++) begin
            link_tx_model_inst.send(1'b0, pat(e));
         end
         begin
            wait_valid();
            repeat (72) @(posedge fwd_clk);
            repeat (16) begin
               @(negedge mclk);
               chk_line(rd_data, exp_line(rd_n % `LINE_BEATS));
               chk_bit(rd_valid, 1'b1);
            end
         end
      join
      chk_bit(sep_err, 1'b1);
      $display("t_start done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      t_reset();
      t_idle();
      t_start();
      t_reset();
      t_idle();
      t_start();
      stop_test();
   end

endmodule // tb
